// >>> core/ctf_counter_front.sv
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "ctf_map.svh"
// How it works
// - nothing runs until armed by software or hardware
// - hardware arm edge starts input measurement
// - start trigger begins generation; continuous runs until disarmed
// - finite makes programmed pulses; retrigger restarts it
// - start trigger is taken from gate input
// - edge counting ignores edges at inactive pause level
// - continuous generation halts at inactive pause level
// - pause trigger is taken from gate input
// - other counter output and tc reach gate
// - enabled filters sample on each 40 MHz tick
// - level passes after N equal consecutive samples
// - setting picks N of 5, 257, 101800, none
// - per-input filter settings, all disabled at reset
// - filter jitter at most one 25 ns tick
// - prescaler divides source by eight or two
// - prescaler count is never readable
// - prescaler only works on external pin sources
// - buffer stores source count between gate rises
// - duplicate prevention touches pin source and gate sampling in every mode
// - without prevention, buffered gate sampled on source edges
// - with prevention, both sampled on 80 MHz tick
// - tc asserts when counter value reaches zero
module ctf_counter_front
   import ctf_pkg::*;
#(
   parameter int unsigned FILT_N_LONG = `CTF_FILT_N_LONG
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] programmable_io_terminal,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] ctr_out
);

   localparam logic [2:0] FILT_LAST = 3'(`CTF_FILT_DIV - 1);
   localparam logic [3:0] TB20_LAST = 4'(`CTF_TB20_DIV - 1);
   localparam logic [10:0] TB100_LAST = 11'(`CTF_TB100K_DIV - 1);
   localparam logic [16:0] N_LONG = 17'(FILT_N_LONG);

   ctf_st_t s;
   ctf_st_t n;

   // --------------------------------------------------
   // read mux
   // --------------------------------------------------
   function automatic logic [31:0] rd_mux(input ctf_st_t st, input logic [6:0] a);
      logic [31:0] d;
      ctf_ctr_t c;
      d = 32'h0;
      c = st.ctr[a[5]];
      if (a[6:5] == `CTF_SEL_MISC) begin
         if (a[4:0] == `CTF_OFF_FILT) begin
            d = {24'h0, st.filt_cfg};
         end
      end else if (a[6] == 1'b1) begin
         // top slot is unmapped and must not alias counter 1
         d = 32'h0;
      end else if (a[4:0] == `CTF_OFF_CTRL) begin
         d = {27'h0, c.pending, c.overrun, c.buf_valid, c.running, c.armed};
      end else if (a[4:0] == `CTF_OFF_CFG) begin
         d = {11'h0, c.cfg};
      end else if (a[4:0] == `CTF_OFF_LOAD) begin
         d = c.load;
      end else if (a[4:0] == `CTF_OFF_NPULSE) begin
         d = c.npulse;
      end else if (a[4:0] == `CTF_OFF_COUNT) begin
         d = c.count;
      end else if (a[4:0] == `CTF_OFF_BUF) begin
         d = c.bufd;
      end
      return d;
   endfunction

   // --------------------------------------------------
   // next state
   // --------------------------------------------------
   always_comb begin
      logic tick_f;
      logic tick80;
      logic tick20;
      logic tick100;
      logic [3:0] acc;
      logic [16:0] nlim;
      logic [1:0] stored;
      ctf_ctr_t c;
      ctf_ctr_t o;
      logic src_raw;
      logic ev;
      logic gate_lvl;
      logic grise;
      logic brise;
      logic paused;
      logic arm_lvl;
      logic arm_rise;
      logic [2:0] plim;
      logic [6:0] a;
      logic is_ctr;
      logic [31:0] wd;
      tick_f = 1'b0;
      tick80 = 1'b0;
      tick20 = 1'b0;
      tick100 = 1'b0;
      acc = 4'h0;
      nlim = 17'h0;
      stored = 2'h0;
      c = '0;
      o = '0;
      src_raw = 1'b0;
      ev = 1'b0;
      gate_lvl = 1'b0;
      grise = 1'b0;
      brise = 1'b0;
      paused = 1'b0;
      arm_lvl = 1'b0;
      arm_rise = 1'b0;
      plim = 3'h0;
      a = avs_address;
      is_ctr = 1'b0;
      wd = avs_writedata;
      n = s;

      // --------------------------------------------------
      // timebases, all as enable pulses off sys_clk
      // --------------------------------------------------
      tick_f = (s.fdiv == FILT_LAST);
      n.fdiv = tick_f ? 3'h0 : s.fdiv + 3'h1;
      tick20 = (s.tb20_cnt == TB20_LAST);
      n.tb20_cnt = tick20 ? 4'h0 : s.tb20_cnt + 4'h1;
      tick100 = (s.tb100_cnt == TB100_LAST);
      n.tb100_cnt = tick100 ? 11'h0 : s.tb100_cnt + 11'h1;
      // 80 MHz on average: two ticks every five cycles, so spacing jitters by one cycle
      acc = {1'b0, s.tb80_acc} + {1'b0, `CTF_TB80_NUM};
      tick80 = (acc >= {1'b0, `CTF_TB80_DEN});
      n.tb80_acc = tick80 ? 3'(acc - {1'b0, `CTF_TB80_DEN}) : acc[2:0];

      // --------------------------------------------------
      // pin synchronisers and debounce filters
      // --------------------------------------------------
      // only the second stage feeds logic
      n.sync1 = programmable_io_terminal;
      n.sync2 = s.sync1;
      for (int k = 0; k < 4; k++) begin
         case (s.filt_cfg[2*k +: 2])
            2'h1: nlim = `CTF_FILT_N_SHORT;
            2'h2: nlim = `CTF_FILT_N_MID;
            2'h3: nlim = N_LONG;
            default: nlim = 17'h0;
         endcase
         if (s.filt_cfg[2*k +: 2] == 2'h0) begin
            n.filt_lvl[k] = s.sync2[k];
            n.filt_cnt[k] = 17'h0;
         end else if (tick_f) begin
            if (s.sync2[k] != s.filt_lvl[k]) begin
               if (s.filt_cnt[k] + 17'h1 == nlim) begin
                  n.filt_lvl[k] = s.sync2[k];
                  n.filt_cnt[k] = 17'h0;
               end else begin
                  n.filt_cnt[k] = s.filt_cnt[k] + 17'h1;
               end
            end else begin
               n.filt_cnt[k] = 17'h0;
            end
         end
      end

      // --------------------------------------------------
      // counters
      // --------------------------------------------------
      for (int i = 0; i < 2; i++) begin
         c = s.ctr[i];
         o = s.ctr[1-i];
         c.tc = 1'b0;

         // external pins seen only at 80 MHz ticks under duplicate prevention
         case (c.cfg.src_sel)
            3'h4: src_raw = tick80;
            3'h5: src_raw = tick20;
            3'h6: src_raw = tick100;
            3'h7: src_raw = o.tc;
            default: begin
               src_raw = 1'b0;
               if (!c.cfg.dup_prev || tick80) begin
                  src_raw = s.filt_lvl[c.cfg.src_sel[1:0]] & ~c.src_q;
                  c.src_q = s.filt_lvl[c.cfg.src_sel[1:0]];
               end
            end
         endcase

         // gate carries start and pause triggers
         case (c.cfg.gate_sel)
            3'h4: gate_lvl = o.out_lvl;
            3'h5: gate_lvl = o.tc;
            3'h6: gate_lvl = 1'b0;
            3'h7: gate_lvl = 1'b0;
            default: gate_lvl = s.filt_lvl[c.cfg.gate_sel[1:0]];
         endcase
         grise = 1'b0;
         if (!c.cfg.dup_prev || tick80) begin
            grise = gate_lvl & ~c.gate_q;
            c.gate_q = gate_lvl;
         end

         // prescaler state stays internal, so up to seven edges go unseen
         ev = src_raw;
         if (src_raw && !c.cfg.src_sel[2] && c.cfg.presc != 2'h0) begin
            plim = (c.cfg.presc == 2'h1) ? 3'h7 : 3'h1;
            ev = (c.pre == plim);
            c.pre = ev ? 3'h0 : c.pre + 3'h1;
         end

         paused = c.cfg.pause_en & (gate_lvl == c.cfg.pause_hi);

         case (c.cfg.arm_sel)
            3'h4: arm_lvl = o.out_lvl;
            3'h5: arm_lvl = 1'b0;
            3'h6: arm_lvl = 1'b0;
            3'h7: arm_lvl = 1'b0;
            default: arm_lvl = s.filt_lvl[c.cfg.arm_sel[1:0]];
         endcase
         arm_rise = arm_lvl & ~c.arm_q;
         c.arm_q = arm_lvl;
         if (c.pending && arm_rise) begin
            c.armed = 1'b1;
            c.pending = 1'b0;
         end

         // non-prevented gate is sampled by the source itself
         brise = c.cfg.dup_prev ? grise : (ev & gate_lvl & ~c.gate_smp);
         if (ev) begin
            c.gate_smp = gate_lvl;
         end

         if (c.armed) begin
            case (c.cfg.mode)
               CTF_EDGE: begin
                  if (ev && !paused) begin
                     c.count = c.count + 32'h1;
                     c.tc = (c.count == 32'h0);
                  end
               end
               CTF_BUFMEAS: begin
                  if (brise) begin
                     c.bufd = c.count;
                     c.count = ev ? 32'h1 : 32'h0;
                     if (c.buf_valid) begin
                        c.overrun = 1'b1;
                     end
                     c.buf_valid = 1'b1;
                     stored[i] = 1'b1;
                  end else if (ev) begin
                     c.count = c.count + 32'h1;
                     c.tc = (c.count == 32'h0);
                  end
               end
               default: begin
                  if (!c.running) begin
                     if (!c.cfg.start_en || grise) begin
                        c.running = 1'b1;
                        c.count = c.load;
                        c.pcnt = 32'h0;
                        c.out_lvl = 1'b0;
                     end
                  end else if (c.cfg.mode == CTF_PGEN_FIN && c.cfg.retrig
                               && c.cfg.start_en && grise) begin
                     c.count = c.load;
                     c.pcnt = 32'h0;
                     c.out_lvl = 1'b0;
                  end else if (ev && !(paused && c.cfg.mode == CTF_PGEN_CONT)) begin
                     if (c.count == 32'h0) begin
                        c.tc = 1'b1;
                        c.count = c.load;
                        c.out_lvl = ~c.out_lvl;
                        if (!c.out_lvl) begin
                           c.pcnt = c.pcnt + 32'h1;
                           if (c.cfg.mode == CTF_PGEN_FIN && c.pcnt >= c.npulse) begin
                              c.running = 1'b0;
                              // else an untriggered finite run would restart at once
                              if (!(c.cfg.retrig && c.cfg.start_en)) begin
                                 c.armed = 1'b0;
                              end
                           end
                        end
                     end else begin
                        c.count = c.count - 32'h1;
                     end
                  end
               end
            endcase
         end
         n.ctr[i] = c;
      end

      // --------------------------------------------------
      // avalon slave: one wait cycle, then the acknowledge edge
      // --------------------------------------------------
      is_ctr = (a[6] == 1'b0);
      if (s.waitreq && (avs_read || avs_write)) begin
         n.rdata = rd_mux(s, a);
         n.waitreq = 1'b0;
      end else if (!s.waitreq) begin
         n.waitreq = 1'b1;
         if (avs_write && a[6:5] == `CTF_SEL_MISC && a[4:0] == `CTF_OFF_FILT) begin
            n.filt_cfg = wd[7:0];
         end else if (avs_write && is_ctr) begin
            if (a[4:0] == `CTF_OFF_CTRL) begin
               if (wd[`CTF_CTRL_ARM]) begin
                  n.ctr[a[5]].pending = n.ctr[a[5]].cfg.hw_arm;
                  n.ctr[a[5]].armed = ~n.ctr[a[5]].cfg.hw_arm;
                  n.ctr[a[5]].running = 1'b0;
                  n.ctr[a[5]].count = 32'h0;
                  n.ctr[a[5]].pre = 3'h0;
               end
               if (wd[`CTF_CTRL_DISARM]) begin
                  n.ctr[a[5]].armed = 1'b0;
                  n.ctr[a[5]].pending = 1'b0;
                  n.ctr[a[5]].running = 1'b0;
               end
               // a store in the same cycle wins over the clear
               if (wd[`CTF_CTRL_CLR_OVR] && !(stored[a[5]] && s.ctr[a[5]].buf_valid)) begin
                  n.ctr[a[5]].overrun = 1'b0;
               end
            end else if (a[4:0] == `CTF_OFF_CFG) begin
               n.ctr[a[5]].cfg = ctf_cfg_t'(wd[`CTF_CFG_W-1:0]);
            end else if (a[4:0] == `CTF_OFF_LOAD) begin
               n.ctr[a[5]].load = wd;
            end else if (a[4:0] == `CTF_OFF_NPULSE) begin
               n.ctr[a[5]].npulse = wd;
            end
         end else if (avs_read && is_ctr && a[4:0] == `CTF_OFF_BUF) begin
            // a store in the same cycle keeps the valid flag up
            if (!stored[a[5]]) begin
               n.ctr[a[5]].buf_valid = 1'b0;
            end
         end
      end

      for (int i = 0; i < 2; i++) begin
         n.ctr_out[i] = (n.ctr[i].cfg.toggle ? n.ctr[i].out_lvl : n.ctr[i].tc)
                        ^ n.ctr[i].cfg.out_inv;
      end
   end

   // --------------------------------------------------
   // state register
   // --------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.filt_cfg <= `CTF_FILT_RST;
         // waitrequest idles high so no access completes in reset
         s.waitreq <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // --------------------------------------------------
   // outputs
   // --------------------------------------------------
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign ctr_out = s.ctr_out;

endmodule

// >>> core/ctf_map.svh
`ifndef CTF_MAP_SVH
`define CTF_MAP_SVH

// --------------------------------------------------
// timing
// --------------------------------------------------
`define CTF_SYS_CLK_NS 5
`define CTF_FILT_CLK_NS 25
`define CTF_FILT_DIV (`CTF_FILT_CLK_NS / `CTF_SYS_CLK_NS)
`define CTF_TB20_NS 50
`define CTF_TB20_DIV (`CTF_TB20_NS / `CTF_SYS_CLK_NS)
`define CTF_TB100K_NS 10000
`define CTF_TB100K_DIV (`CTF_TB100K_NS / `CTF_SYS_CLK_NS)
`define CTF_TB80_NUM 3'h2
`define CTF_TB80_DEN 3'h5
`define CTF_FILT_N_SHORT 17'h00005
`define CTF_FILT_N_MID 17'h00101
`define CTF_FILT_N_LONG 101800

// --------------------------------------------------
// register map
// --------------------------------------------------
`define CTF_SEL_CTR1 2'h1
`define CTF_SEL_MISC 2'h2
`define CTF_OFF_CTRL 5'h00
`define CTF_OFF_CFG 5'h04
`define CTF_OFF_LOAD 5'h08
`define CTF_OFF_NPULSE 5'h0c
`define CTF_OFF_COUNT 5'h10
`define CTF_OFF_BUF 5'h14
`define CTF_OFF_FILT 5'h00
`define CTF_CTRL_ARM 0
`define CTF_CTRL_DISARM 1
`define CTF_CTRL_CLR_OVR 2
`define CTF_CFG_W 21
`define CTF_FILT_RST 8'h00

`endif

// >>> core/ctf_pkg.sv
package ctf_pkg;

   typedef enum logic [1:0] {
      CTF_EDGE,
      CTF_BUFMEAS,
      CTF_PGEN_CONT,
      CTF_PGEN_FIN
   } ctf_mode_t;

   typedef struct packed {
      logic out_inv;
      logic toggle;
      logic dup_prev;
      logic [1:0] presc;
      logic retrig;
      logic start_en;
      logic pause_hi;
      logic pause_en;
      logic hw_arm;
      logic [2:0] arm_sel;
      logic [2:0] gate_sel;
      logic [2:0] src_sel;
      ctf_mode_t mode;
   } ctf_cfg_t;

   typedef struct packed {
      ctf_cfg_t cfg;
      logic [31:0] load;
      logic [31:0] npulse;
      logic [31:0] count;
      logic [31:0] pcnt;
      logic [31:0] bufd;
      logic armed;
      logic pending;
      logic running;
      logic buf_valid;
      logic overrun;
      logic out_lvl;
      logic tc;
      logic src_q;
      logic gate_q;
      logic gate_smp;
      logic arm_q;
      logic [2:0] pre;
   } ctf_ctr_t;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] filt_lvl;
      logic [3:0][16:0] filt_cnt;
      logic [7:0] filt_cfg;
      logic [2:0] fdiv;
      logic [2:0] tb80_acc;
      logic [3:0] tb20_cnt;
      logic [10:0] tb100_cnt;
      ctf_ctr_t [1:0] ctr;
      logic [1:0] ctr_out;
      logic [31:0] rdata;
      logic waitreq;
   } ctf_st_t;

endpackage

// >>> sim/ctf_counter_front_asserts.sv
`timescale 1ns/100ps
module ctf_counter_front_asserts #(
   parameter int unsigned FILT_N_LONG = 101800
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] programmable_io_terminal,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] ctr_out
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // no write yet means nothing can be armed or configured
   logic wr_seen_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) wr_seen_r <= 1'b0;
      else if (avs_write) wr_seen_r <= 1'b1;
   end
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_take_ack;
      s_take |=> s_ack;
   endproperty
   property p_ack_cause;
      !avs_waitrequest |-> $past(avs_read || avs_write);
   endproperty
   property p_idle_wait;
      !(avs_read || avs_write) |=> avs_waitrequest;
   endproperty
   property p_rd_hold;
      avs_waitrequest && !(avs_read || avs_write) |=> $stable(avs_readdata);
   endproperty
   property p_unmapped;
      avs_read && avs_waitrequest && avs_address[6:5] == 2'h3 |=> avs_readdata == 32'h0;
   endproperty
   property p_unarmed_quiet;
      !wr_seen_r |-> ctr_out == 2'h0;
   endproperty
   property p_filt_reset;
      avs_read && avs_waitrequest && avs_address == 7'h40 && !wr_seen_r |=> avs_readdata == 0;
   endproperty
   property p_ctrl_reset;
      avs_read && avs_waitrequest && avs_address == 7'h00 && !wr_seen_r |=> avs_readdata == 0;
   endproperty
   a_take_ack: assert property (p_take_ack) else $error("no single wait cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_idle_wait: assert property (p_idle_wait) else $error("wait low while idle");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("output active unarmed");
   a_filt_reset: assert property (p_filt_reset) else $error("filter on after reset");
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("counter armed at reset");
endmodule
bind ctf_counter_front ctf_counter_front_asserts #(.FILT_N_LONG(FILT_N_LONG)) u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .programmable_io_terminal(programmable_io_terminal),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ctr_out(ctr_out)
);

// >>> sim/ctf_pin_model.sv
`timescale 1ns/100ps
module ctf_pin_model (
   input wire logic sys_clk,
   output logic [3:0] pins
);
   initial pins = 4'h0;
   task automatic set_pin(input int i, input logic v);
      @(posedge sys_clk);
      pins[i] <= v;
   endtask
   task automatic pulse(input int i, input int hi, input int lo);
      set_pin(i, 1'b1);
      repeat (hi - 1) @(posedge sys_clk);
      set_pin(i, 1'b0);
      repeat (lo - 1) @(posedge sys_clk);
   endtask
endmodule

// >>> sim/test_ctf_counter_front.sv
`timescale 1ns/100ps
module test_ctf_counter_front;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] pins;
   logic [6:0] avs_address = 7'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] ctr_out;
   logic [31:0] rd;
   logic prev_out = 1'b0;
   int fail_count = 0;
   int total_checks = 0;
   int rises = 0;
   int cyc = 0;
   int n;
   int k;
   int w;
   ctf_counter_front #(.FILT_N_LONG(20)) u_ctf_counter_front (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .programmable_io_terminal(pins),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ctr_out(ctr_out)
   );
   ctf_pin_model u_ctf_pin_model (.sys_clk(sys_clk), .pins(pins));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] src,
         input logic [2:0] gate, input logic [3:0] fl, input logic [1:0] ps);
      // fl = toggle, dup_prev, pause_hi, pause_en
      return {12'h0, fl[3], fl[2], ps, 2'h0, fl[1], fl[0], 4'h0, gate, src, m};
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic r, input logic [6:0] a, input logic [31:0] d);
      int t;
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= r;
      avs_write <= !r;
      avs_writedata <= d;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 40);
      rd = avs_readdata;
      if (t >= 40) fail_count++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
      xfer(1'b1, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic pulses(input int i, input int c, input int hi, input int lo);
      repeat (c) u_ctf_pin_model.pulse(i, hi, lo);
      repeat (30) @(posedge sys_clk);
   endtask
   // bounded run; a hang counts as a mismatch
   always @(posedge sys_clk) begin
      prev_out <= ctr_out[0];
      if (ctr_out[0] === 1'b1 && prev_out === 1'b0) rises++;
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         test_done();
      end
   end
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   initial begin
      void'($urandom(32'h2c0c));
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdchk(7'h40, 32'h0);
      rdchk(7'h00, 32'h0);
      rdchk(7'h60, 32'h0);
      xfer(1'b0, 7'h04, cfg(2'h0, 3'h0, 3'h6, 4'h0, 2'h0));
      pulses(0, 3, 4, 4);
      rdchk(7'h10, 32'h0);
      n = $urandom_range(12, 3);
      xfer(1'b0, 7'h00, 32'h1);
      pulses(0, n, 4, 4);
      rdchk(7'h10, n);
      xfer(1'b0, 7'h00, 32'h2);
      pulses(0, 2, 4, 4);
      rdchk(7'h10, n);
      for (k = 0; k < 2; k++) begin
         xfer(1'b0, 7'h04, cfg(2'h0, 3'h0, 3'h1, {2'b0, k[0], 1'b1}, 2'h0));
         u_ctf_pin_model.set_pin(1, k[0]);
         xfer(1'b0, 7'h00, 32'h1);
         pulses(0, 3, 4, 4);
         u_ctf_pin_model.set_pin(1, !k[0]);
         repeat (8) @(posedge sys_clk);
         pulses(0, n, 4, 4);
         rdchk(7'h10, n);
      end
      u_ctf_pin_model.set_pin(1, 1'b0);
      for (k = 1; k < 3; k++) begin
         xfer(1'b0, 7'h04, cfg(2'h0, 3'h0, 3'h6, 4'h0, k[1:0]));
         xfer(1'b0, 7'h00, 32'h1);
         pulses(0, 16, 4, 4);
         rdchk(7'h10, (k == 1) ? 32'h2 : 32'h8);
      end
      // internal source must ignore the divider: 400 cycles hold about 40 ticks
      xfer(1'b0, 7'h04, cfg(2'h0, 3'h5, 3'h6, 4'h0, 2'h1));
      xfer(1'b0, 7'h00, 32'h1);
      repeat (400) @(posedge sys_clk);
      xfer(1'b1, 7'h10, 32'h0);
      chk({31'h0, rd > 32'd20}, 32'h1);
      for (k = 1; k < 4; k++) begin
         w = (k == 1) ? 5 : (k == 2) ? 257 : 20;
         xfer(1'b0, 7'h40, {30'h0, k[1:0]});
         rdchk(7'h40, k);
         xfer(1'b0, 7'h04, cfg(2'h0, 3'h0, 3'h6, 4'h0, 2'h0));
         xfer(1'b0, 7'h00, 32'h1);
         pulses(0, 2, w * 5 - 15, w * 5 - 15);
         pulses(0, 2, w * 5 + 20, w * 5 + 20);
         rdchk(7'h10, 32'h2);
      end
      xfer(1'b0, 7'h40, 32'h0);
      xfer(1'b0, 7'h04, cfg(2'h1, 3'h0, 3'h2, 4'h4, 2'h0));
      xfer(1'b0, 7'h00, 32'h1);
      u_ctf_pin_model.pulse(2, 8, 8);
      repeat (10) @(posedge sys_clk);
      xfer(1'b1, 7'h00, 32'h0);
      chk(rd & 32'h4, 32'h4);
      xfer(1'b1, 7'h14, 32'h0);
      for (k = 0; k < 2; k++) begin
         n = (k == 0) ? 0 : $urandom_range(9, 1);
         pulses(0, n, 6, 6);
         u_ctf_pin_model.pulse(2, 8, 8);
         repeat (10) @(posedge sys_clk);
         rdchk(7'h14, n);
      end
      xfer(1'b0, 7'h08, 32'h0);
      xfer(1'b0, 7'h0c, 32'h3);
      xfer(1'b0, 7'h04, cfg(2'h3, 3'h5, 3'h6, 4'h8, 2'h0));
      rises = 0;
      xfer(1'b0, 7'h00, 32'h1);
      repeat (300) @(posedge sys_clk);
      chk(rises, 32'h3);
      xfer(1'b1, 7'h00, 32'h0);
      chk(rd & 32'h2, 32'h0);
      u_ctf_pin_model.set_pin(1, 1'b1);
      xfer(1'b0, 7'h04, cfg(2'h2, 3'h5, 3'h1, 4'hb, 2'h0));
      rises = 0;
      xfer(1'b0, 7'h00, 32'h1);
      repeat (200) @(posedge sys_clk);
      chk(rises, 32'h0);
      u_ctf_pin_model.set_pin(1, 1'b0);
      repeat (200) @(posedge sys_clk);
      chk({31'h0, rises > 5}, 32'h1);
      xfer(1'b0, 7'h00, 32'h2);
      // a toggle launched on the disarm edge is seen one edge later
      repeat (3) @(posedge sys_clk);
      k = rises;
      repeat (100) @(posedge sys_clk);
      chk(rises, k);
      // hardware arm, gate start, retrigger; counter 1 counts while counter 0 is high
      xfer(1'b0, 7'h0c, 32'h2);
      xfer(1'b0, 7'h04, cfg(2'h3, 3'h5, 3'h1, 4'h8, 2'h0) | 32'h0000cb00);
      rises = 0;
      xfer(1'b0, 7'h00, 32'h1);
      xfer(1'b1, 7'h00, 32'h0);
      chk(rd & 32'h11, 32'h10);
      u_ctf_pin_model.pulse(1, 4, 4);
      u_ctf_pin_model.pulse(3, 4, 60);
      chk(rises, 32'h0);
      u_ctf_pin_model.pulse(1, 4, 100);
      chk(rises, 32'h2);
      xfer(1'b0, 7'h24, cfg(2'h0, 3'h5, 3'h4, 4'h1, 2'h0));
      xfer(1'b0, 7'h20, 32'h1);
      repeat (40) @(posedge sys_clk);
      rdchk(7'h30, 32'h0);
      u_ctf_pin_model.pulse(1, 4, 100);
      chk(rises, 32'h4);
      rdchk(7'h30, 32'h2);
      test_done();
   end
endmodule
